// file: hdl/smcr_device.sv
// device end: shifts in command words and keeps the motor drive state
// assumes link pins are asynchronous to clk_in and slower than 4 clocks
// assumes the host sends whole words; a cut frame is simply dropped
// the power stage is outside: these outputs only say what to drive
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module smcr_device (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    smcr_link_if.device      link,
    output logic             drive_en_out,   // phase drivers active
    output logic             hold_out,       // lock: energised hold
    output logic             brake_out,      // brake: short-halt
    output logic             dir_cw_out,     // 1 clockwise, 0 ccw
    output logic [7:0]       speed_out,      // current setpoint
    output logic             word_valid_out  // one-cycle pulse per word
);
    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers, one per link pin; the first stage feeds only the
    // second, so a metastable first stage never reaches the decode logic
    // reset loads the idle pin levels so no false edge follows reset
    // cost: every link event is seen two clocks late, which the host allows
    wire [2:0] pin_raw = {link.sel_n, link.sclk, link.sdata};
    wire [2:0] pin_sync;
    for (genvar p = 0; p < 3; p++) begin : g_sync
        logic stage1;
        logic stage2;
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                stage1 <= smcr_pkg::PIN_IDLE[p];
                stage2 <= smcr_pkg::PIN_IDLE[p];
            end else begin
                stage1 <= pin_raw[p];
                stage2 <= stage1;
            end
        end
        assign pin_sync[p] = stage2;
    end
    wire sel_n_s = pin_sync[2];
    wire sclk_s  = pin_sync[1];
    wire sdata_s = pin_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // edge detectors on the synchronised select and shift clock
    // the link must hold each level for at least two clocks or an edge is lost
    // both start at the idle levels, matching the synchronisers above
    logic sclk_d;
    logic sel_n_d;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_d  <= smcr_pkg::PIN_IDLE[1];
            sel_n_d <= smcr_pkg::PIN_IDLE[2];
        end else begin
            sclk_d  <= sclk_s;
            sel_n_d <= sel_n_s;
        end
    end
    // shift clock rises count only inside a frame
    wire sclk_rise = sclk_s && !sclk_d && !sel_n_s;
    // select rise marks the end of a frame; the word is judged here
    wire sel_rise  = sel_n_s && !sel_n_d;

    ////////////////////////////////////////////////////////////////////////////
    // shift register and bit counter
    // the register keeps only the last eleven bits seen; the count alone
    // decides whether they form a word, so a stray pulse cannot pass
    logic [10:0] shift;
    logic [3:0]  count;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift <= smcr_pkg::WORD_RESET;
            count <= 4'h_0;
        end else begin
            if (sel_n_s) begin
                count <= 4'h_0;
            end else if (sclk_rise) begin
                shift <= {shift[9:0], sdata_s};
                // saturate past full so overruns stay invalid
                if (count != 4'h_f) begin
                    count <= count + 4'h_1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word decode on select rise; only exact eleven-bit words count
    // a short or long frame is dropped silently; the host gets no sign of it
    wire accept     = sel_rise && (count == smcr_pkg::CNT_FULL);
    // special words are whole-word matches and carry no rotation pattern
    wire is_lock    = shift == smcr_pkg::CMD_LOCK;
    wire is_brake   = shift == smcr_pkg::CMD_BRAKE;
    wire is_disable = shift == smcr_pkg::CMD_DISABLE;
    wire is_run     = shift == smcr_pkg::CMD_RUN;
    wire is_stop    = is_lock || is_brake || is_disable;
    // rotation field leads the word, speed field trails it
    wire [2:0] rot  = shift[smcr_pkg::ROT_MSB:smcr_pkg::ROT_LSB];
    wire [7:0] spd  = shift[smcr_pkg::SPEED_MSB:smcr_pkg::SPEED_LSB];
    wire is_cw      = rot == smcr_pkg::ROT_CW;
    wire is_ccw     = rot == smcr_pkg::ROT_CCW;
    // any other rotation pattern that is not special is ignored
    wire is_speed   = (is_cw || is_ccw) && !is_run;
    wire take_speed = accept && is_speed;
    wire take_stop  = accept && is_stop;

    ////////////////////////////////////////////////////////////////////////////
    // motor state; a speed word only arms, run starts it
    // run is refused until a speed word follows every stop, so a stale
    // setpoint left from before a stop can never restart the motor
    // idle:  after reset, nothing driven until armed and run
    // run:   phase drives follow rotation and setpoint
    // lock:  phases energised to hold position
    // brake: one-cycle halt, then off
    // off:   all drivers released, motor coasts
    smcr_pkg::smcr_motor_t state;
    smcr_pkg::smcr_motor_t next_state;
    logic armed;      // speed word received since last stop
    always_comb begin
        next_state = state;
        if (accept) begin
            unique case (1'b1)
                is_lock:    next_state = smcr_pkg::MOT_LOCK;
                is_brake:   next_state = smcr_pkg::MOT_BRAKE;
                is_disable: next_state = smcr_pkg::MOT_OFF;
                is_run:     next_state = armed ? smcr_pkg::MOT_RUN : state;
                default:    next_state = state;
            endcase
        end else if (state == smcr_pkg::MOT_BRAKE) begin
            // brake is a one-cycle halt, after which the drives stay off
            next_state = smcr_pkg::MOT_OFF;
        end
    end

    // state and arming; a stop word always disarms
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= smcr_pkg::MOT_IDLE;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            if (take_speed) begin
                armed <= 1'b1;
            end else if (take_stop) begin
                armed <= 1'b0;
            end
        end
    end

    // setpoint and direction; a speed word while running takes effect at once
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            speed_out  <= smcr_pkg::SPEED_RESET;
            dir_cw_out <= 1'b1;
        end else if (take_speed) begin
            speed_out  <= spd;
            dir_cw_out <= is_cw;
        end
    end

    // one pulse per accepted word, in step with the outputs it changes
    // a dropped frame gives no pulse, which is the only way to see it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_valid_out <= 1'b0;
        end else begin
            word_valid_out <= accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered drive outputs, decoded from the next state so they change
    // on the same edge as the state itself; no acknowledge line exists
    // one state at a time, so drive, hold and brake never overlap
    wire next_drive = next_state == smcr_pkg::MOT_RUN;
    wire next_hold  = next_state == smcr_pkg::MOT_LOCK;
    wire next_brake = next_state == smcr_pkg::MOT_BRAKE;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            drive_en_out <= 1'b0;
            hold_out     <= 1'b0;
            brake_out    <= 1'b0;
        end else begin
            drive_en_out <= next_drive;
            hold_out     <= next_hold;
            brake_out    <= next_brake;
        end
    end
endmodule
`default_nettype wire

// file: hdl/smcr_host.sv
// host end: sends one eleven-bit word per send request over the link; an init request sends none
// assumes requests come from logic on clk_in; shift clock divided from clk_in
`timescale 1ns/10ps
`default_nettype none
module smcr_host (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        send_in,      // pulse: start a word
    input  wire logic        init_in,      // pulse: select high-low-high
    input  wire logic [10:0] word_in,      // word, sent msb first
    output logic             busy_out,
    smcr_link_if.host        link
);
    typedef enum logic [1:0] {H_IDLE, H_INIT, H_SHIFT, H_END} smcr_hstate_t;
    smcr_hstate_t state;
    logic [10:0]  sreg;
    logic [3:0]   bits;
    logic [3:0]   half;
    wire tick = half == smcr_pkg::HALF_CNT;

    ////////////////////////////////////////////////////////////////////////////
    // one half-period per tick; select low covers exactly eleven rises for a word, none for init
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state      <= H_IDLE;
            sreg       <= smcr_pkg::WORD_RESET;
            bits       <= 4'h_0;
            half       <= 4'h_0;
            busy_out   <= 1'b0;
            link.sel_n <= 1'b1;
            link.sclk  <= 1'b0;
            link.sdata <= 1'b0;
        end else begin
            half <= tick ? 4'h_0 : half + 4'h_1;
            unique case (state)
                H_IDLE: begin
                    half <= 4'h_0;
                    if (send_in) begin
                        sreg       <= {word_in[9:0], 1'b0};
                        link.sdata <= word_in[10];
                        link.sel_n <= 1'b0;
                        bits       <= 4'h_0;
                        busy_out   <= 1'b1;
                        state      <= H_SHIFT;
                    end else if (init_in) begin
                        link.sel_n <= 1'b0;
                        busy_out   <= 1'b1;
                        state      <= H_INIT;
                    end
                end
                H_INIT: if (tick) begin
                    link.sel_n <= 1'b1;
                    state      <= H_END;
                end
                H_SHIFT: if (tick) begin
                    link.sclk <= !link.sclk;
                    if (link.sclk) begin
                        link.sdata <= sreg[10];
                        sreg       <= {sreg[9:0], 1'b0};
                    end else if (bits == smcr_pkg::CNT_FULL - 4'h_1) begin
                        state <= H_END;                    // no ack clock
                    end else begin
                        bits <= bits + 4'h_1;
                    end
                end
                H_END: if (tick) begin
                    // clock low first, select high one half period later
                    link.sclk <= 1'b0;
                    if (!link.sclk) begin
                        link.sel_n <= 1'b1;
                    end
                    if (link.sel_n) begin
                        busy_out <= 1'b0;
                        state    <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: hdl/smcr_link_if.sv
// three-wire link: active-low select, data, rising-edge shift clock
// assumes one host and one device; all lines driven by the host only
`timescale 1ns/10ps
`default_nettype none
interface smcr_link_if;
    logic sel_n;   // chip select, active low
    logic sdata;   // serial data
    logic sclk;    // shift clock, sampled on rising edge
    modport host   (output sel_n, output sdata, output sclk);
    modport device (input sel_n, input sdata, input sclk);
endinterface
`default_nettype wire

// file: hdl/smcr_pkg.sv
// package of constants shared by both ends of the serial motor command link
// assumes both ends run on one 50 MHz system clock
package smcr_pkg;
    // word layout: rotation field first, speed field last, msb first
    localparam int unsigned WORD_BITS   = 11;
    localparam int unsigned ROT_BITS    = 3;
    localparam int unsigned SPEED_BITS  = 8;
    localparam int unsigned ROT_MSB     = 10;
    localparam int unsigned ROT_LSB     = 8;
    localparam int unsigned SPEED_MSB   = 7;
    localparam int unsigned SPEED_LSB   = 0;
    localparam int unsigned CNT_BITS    = 4;
    localparam logic [3:0]  CNT_FULL    = 4'h_b;
    // rotation patterns
    localparam logic [2:0]  ROT_CW      = 3'h_5;
    localparam logic [2:0]  ROT_CCW     = 3'h_4;
    // special command words; real codes not known, values arbitrary
    localparam logic [10:0] CMD_LOCK    = 11'h_000;
    localparam logic [10:0] CMD_BRAKE   = 11'h_001;
    localparam logic [10:0] CMD_DISABLE = 11'h_002;
    localparam logic [10:0] CMD_RUN     = 11'h_003;
    // reset values
    localparam logic [10:0] WORD_RESET  = 11'h_000;
    localparam logic [7:0]  SPEED_RESET = 8'h_00;
    // idle link levels, {select, clock, data}: select high, clock low, data low
    localparam logic [2:0]  PIN_IDLE    = 3'h_4;
    // host timing: shift clock period in system clocks (160 ns at 20 ns)
    localparam int unsigned SYS_CLK_NS     = 20;
    localparam int unsigned SCLK_PERIOD_NS = 160;
    localparam int unsigned SCLK_HALF      = SCLK_PERIOD_NS / SYS_CLK_NS / 2;
    localparam logic [3:0]  HALF_CNT       = 4'(SCLK_HALF - 1);
    // motor drive states
    typedef enum logic [2:0] {
        MOT_IDLE, MOT_RUN, MOT_LOCK, MOT_BRAKE, MOT_OFF
    } smcr_motor_t;
endpackage

// file: verif/smcr_asserts.sv
// checker: timing relations on the three-wire link and the device outputs
// assumes the bench wires it beside the interface, all on clk_in
`timescale 1ns/10ps
`default_nettype none
module smcr_asserts (
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       sel_n,
    input wire logic       sdata,
    input wire logic       sclk,
    input wire logic       drive_en_out,
    input wire logic       hold_out,
    input wire logic       brake_out,
    input wire logic [7:0] speed_out,
    input wire logic       word_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic       sclk_q;
    logic [3:0] rise_cnt;
    ////////////////////////////////////////////////////////////////////////////
    // count shift clock rises per frame; cleared while select is high
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q   <= 1'b0;
            rise_cnt <= 4'h_0;
        end else begin
            sclk_q   <= sclk;
            rise_cnt <= sel_n ? 4'h_0 : rise_cnt + 4'(sclk && !sclk_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_frame_count: assert property ($rose(sel_n) |-> rise_cnt == 4'h_b || rise_cnt == 4'h_0)
        else $error("frame ended with a bad clock count");
    chk_sclk_idle: assert property (sel_n |-> !sclk)
        else $error("shift clock not idle while deselected");
    chk_data_steady: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("data moved at a shift clock rise");
    chk_valid_pulse: assert property (word_valid_out |=> !word_valid_out)
        else $error("word valid longer than one cycle");
    chk_valid_sel: assert property (word_valid_out |-> sel_n)
        else $error("word accepted while select low");
    chk_drive_excl: assert property (drive_en_out |-> !hold_out && !brake_out)
        else $error("drive overlaps hold or brake");
    chk_brake_short: assert property (brake_out |=> !brake_out && !drive_en_out && !hold_out)
        else $error("brake not followed by drives off");
    chk_start_word: assert property ($rose(drive_en_out) |-> word_valid_out)
        else $error("motor started without a word");
    chk_speed_word: assert property ($changed(speed_out) |-> word_valid_out)
        else $error("setpoint changed without a word");
    chk_hold_word: assert property ($rose(hold_out) |-> word_valid_out)
        else $error("hold began without a word");
    cov_start: cover property ($rose(drive_en_out));
    cov_hold: cover property ($rose(hold_out));
    cov_brake: cover property (brake_out);
endmodule
`default_nettype wire

// file: verif/tb.sv
// bench: host and device joined by the link; integer model checks outputs
// assumes the host waits for busy_out low between requests
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_in = 1'b0, resetn_in = 1'b0, send_in = 1'b0, init_in = 1'b0, busy_out;
    logic [10:0] word_in = 11'h_000, last_w = 11'h_000, mon_w = 11'h_000;
    logic drive_en_out, hold_out, brake_out, dir_cw_out, word_valid_out;
    logic [7:0] speed_out;
    integer fail_count = 0, checks_done = 0, cyc = 0, seed = 80872, mon_n = 0, i;
    integer m_drive = 0, m_hold = 0, m_speed = 0, m_dir = 1, m_arm = 0;
    integer m_words = 0, m_brakes = 0, n_words = 0, n_brakes = 0;
    integer ops [16] = '{4, 1, 4, 5, 3, 0, 1, 4, 0, 4, 1, 2, 1, 4, 1, 3};
    smcr_link_if link ();
    smcr_host smcr_host_i (.clk_in(clk_in), .resetn_in(resetn_in), .send_in(send_in),
        .init_in(init_in), .word_in(word_in), .busy_out(busy_out), .link(link.host));
    smcr_device smcr_device_i (.clk_in(clk_in), .resetn_in(resetn_in), .link(link.device),
        .drive_en_out(drive_en_out), .hold_out(hold_out), .brake_out(brake_out),
        .dir_cw_out(dir_cw_out), .speed_out(speed_out), .word_valid_out(word_valid_out));
    smcr_asserts smcr_asserts_i (.clk_in(clk_in), .resetn_in(resetn_in), .sel_n(link.sel_n),
        .sdata(link.sdata), .sclk(link.sclk), .drive_en_out(drive_en_out),
        .hold_out(hold_out), .brake_out(brake_out), .speed_out(speed_out),
        .word_valid_out(word_valid_out));
    always #10 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // cut a hang short; a full run needs about 1700 cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            test_done();
        end
    end
    // wire monitor: rebuild the word from data seen at shift clock rises
    always @(posedge link.sclk) if (!link.sel_n) begin
        mon_w = {mon_w[9:0], link.sdata};
        mon_n++;
    end
    always @(posedge link.sel_n) if (mon_n != 0) begin
        check("wire word", mon_w, last_w);
        check("wire bits", 11'(mon_n), 11'd11);
        mon_n = 0;
    end
    // one-cycle outputs counted mid-cycle, away from the edge that sets them
    always @(negedge clk_in) begin
        if (word_valid_out === 1'b1) n_words++;
        if (brake_out === 1'b1) n_brakes++;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one request, then settle past the device decode latency
    task automatic request(input logic [10:0] w, input logic ini);
        integer n;
        @(posedge clk_in); #2;
        word_in = w;
        send_in = !ini;
        init_in = ini;
        if (!ini) last_w = w;
        @(posedge clk_in); #2;
        send_in = 1'b0;
        init_in = 1'b0;
        for (n = 0; n < 400 && busy_out !== 1'b0; n++) @(posedge clk_in);
        repeat (6) @(posedge clk_in);
    endtask
    // model: stop words disarm, a speed word arms, run starts only when armed
    task automatic apply(input logic [10:0] w);
        m_words++;
        if (w == smcr_pkg::CMD_BRAKE) m_brakes++;
        if (w == smcr_pkg::CMD_LOCK) {m_drive, m_hold, m_arm} = {32'd0, 32'd1, 32'd0};
        else if (w == smcr_pkg::CMD_BRAKE || w == smcr_pkg::CMD_DISABLE)
            {m_drive, m_hold, m_arm} = 96'd0;
        else if (w == smcr_pkg::CMD_RUN) begin
            if (m_arm) {m_drive, m_hold} = {32'd1, 32'd0};
        end else if (w[10:8] == smcr_pkg::ROT_CW || w[10:8] == smcr_pkg::ROT_CCW) begin
            m_speed = w[7:0];
            m_dir = (w[10:8] == smcr_pkg::ROT_CW);
            m_arm = 1;
        end
    endtask
    initial begin
        logic [10:0] w;
        repeat (16) @(posedge clk_in);
        #2 resetn_in = 1'b1;
        request(11'h_000, 1'b1);
        for (i = 0; i < 16; i++) begin
            w = 11'($random(seed));
            case (ops[i])
                0: w = smcr_pkg::CMD_LOCK;
                1: w = smcr_pkg::CMD_RUN;
                2: w = smcr_pkg::CMD_BRAKE;
                3: w = smcr_pkg::CMD_DISABLE;
                4: w[10:8] = w[0] ? smcr_pkg::ROT_CW : smcr_pkg::ROT_CCW;
                default: w[10:8] = 3'h_3;
            endcase
            request(w, 1'b0);
            apply(w);
            check("drive", 11'(drive_en_out), 11'(m_drive));
            check("hold", 11'(hold_out), 11'(m_hold));
            check("brake", 11'(brake_out), 11'd0);
            check("words", 11'(n_words), 11'(m_words));
            check("brake pulses", 11'(n_brakes), 11'(m_brakes));
            check("dir", 11'(dir_cw_out), 11'(m_dir));
            check("speed", 11'(speed_out), 11'(m_speed));
            $display("test %0d done", i);
        end
        test_done();
    end
endmodule
`default_nettype wire
